// File: hw/etfr_regs.sv
// Purpose: fault flags, flight window and reference clock registers
// Assumes: clk_in is the reference clock, analog events arrive on pins
// Notes:   AXI4-Lite slave, 8-bit registers in the low byte lane
//
// Notes on behaviour
// - weak flag sets on timeout when a crossing or signal came but too few crossings
// - no-echo flag sets on timeout when nothing at all was received
// - writing one to no-echo aborts the measurement, back to ready
// - over-range flag sets only while qualify threshold is seven
// - writing one to over-range clears all flags, fault pin goes high unless a flag sets in that same cycle
// - force bit one adds the short flight blanking phase
// - blanking lasts eight base periods doubled per code step
// - echo wait bit zero enables the listen timeout, one disables it
// - listen window is 128, 256, 512 or 1024 base periods
// - halver bit selects base period of one or two clocks
`timescale 1ns/1ps
module etfr_regs (
  // clock and reset
  input  wire logic                         clk_in,
  input  wire logic                         rstn_in,
  // axi4-lite write
  input  wire logic [etfr_pkg::ADDR_W-1:0]  awaddr_in,
  input  wire logic                         awvalid_in,
  output logic                              awready_out,
  input  wire logic [31:0]                  wdata_in,
  input  wire logic [3:0]                   wstrb_in,
  input  wire logic                         wvalid_in,
  output logic                              wready_out,
  output logic [1:0]                        bresp_out,
  output logic                              bvalid_out,
  input  wire logic                         bready_in,
  // axi4-lite read
  input  wire logic [etfr_pkg::ADDR_W-1:0]  araddr_in,
  input  wire logic                         arvalid_in,
  output logic                              arready_out,
  output logic [31:0]                       rdata_out,
  output logic [1:0]                        rresp_out,
  output logic                              rvalid_out,
  input  wire logic                         rready_in,
  // receive path pins
  input  wire etfr_pkg::etfr_rx_s           rx_in,
  // status pins
  output logic                              fault_pin_n_out,
  output logic                              busy_out,
  output logic                              irq_out
);

  // ------------------------------------------------------------------
  // pin synchronisers, three stages, change counts when 2 and 3 agree
  // ------------------------------------------------------------------
  etfr_pkg::etfr_rx_s sync1, sync2, sync3, rx_stable, rx_prev;
  etfr_pkg::etfr_rx_s next_stable, rx_rise;

  always_comb begin
    next_stable = rx_stable;
    for (int i = 0; i < 4; i++) begin
      if (sync2[i] == sync3[i]) begin
        next_stable[i] = sync3[i];
      end
    end
    rx_rise = rx_stable & ~rx_prev;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync1     <= '0;
      sync2     <= '0;
      sync3     <= '0;
      rx_stable <= '0;
      rx_prev   <= '0;
    end else begin
      sync1     <= rx_in;
      sync2     <= sync1;
      sync3     <= sync2;
      rx_stable <= next_stable;
      rx_prev   <= rx_stable;
    end
  end

  // ------------------------------------------------------------------
  // registers and bus slave state
  // ------------------------------------------------------------------
  logic [7:0]  flight_window_config, ref_clock_config, echo_config;
  logic [2:0]  fault_flags;
  logic [3:0]  irq_status, irq_mask;
  logic [7:0]  aw_idx, ar_idx;
  logic        aw_held, w_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic [7:0]  next_flight, next_refclk, next_echo;
  logic [3:0]  next_irq_mask;
  logic        wr_go, wr_lane0, wr_flags, rd_go, rd_hit;
  logic        next_aw_held, next_w_held, next_bvalid, next_rvalid;
  logic [7:0]  next_aw_idx;
  logic [31:0] next_w_data, next_rdata;
  logic [3:0]  next_w_strb;
  logic [1:0]  next_bresp, next_rresp;
  logic        wr_hit;

  // ------------------------------------------------------------------
  // measurement sequencer state
  // ------------------------------------------------------------------
  etfr_pkg::etfr_state_e state, next_state;
  logic        base_phase, next_phase, base_tick;
  logic [3:0]  crossings, next_crossings;
  logic        seen, next_seen;
  logic        tmr_load, tmr_done, abort;
  logic [10:0] tmr_len;
  logic        timeout_evt, done_evt, weak_evt, none_evt, over_evt;
  logic [2:0]  next_flags;
  logic [3:0]  next_irq_status, irq_events;

  // ------------------------------------------------------------------
  // axi4-lite slave, address and data may arrive in either order
  // ------------------------------------------------------------------
  always_comb begin
    wr_go        = aw_held && w_held && !bvalid_out;
    wr_lane0     = wr_go && w_strb[0];
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_idx  = aw_idx;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    if (awvalid_in && !aw_held) begin
      next_aw_held = 1'b1;
      next_aw_idx  = {2'b00, awaddr_in[7:2]};
    end
    if (wvalid_in && !w_held) begin
      next_w_held = 1'b1;
      next_w_data = wdata_in;
      next_w_strb = wstrb_in;
    end
    if (wr_go) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
    end
    wr_hit = (aw_idx >= etfr_pkg::IDX_FAULT_FLAGS) &&
             (aw_idx <= etfr_pkg::IDX_MEAS_STATUS);
    next_bvalid = bvalid_out;
    next_bresp  = bresp_out;
    if (wr_go) begin
      next_bvalid = 1'b1;
      next_bresp  = wr_hit ? etfr_pkg::RESP_OKAY : etfr_pkg::RESP_SLVERR;
    end else if (bready_in) begin
      next_bvalid = 1'b0;
    end
    wr_flags = wr_lane0 && (aw_idx == etfr_pkg::IDX_FAULT_FLAGS);
    // reserved bits of the config registers keep what software wrote
    next_flight   = flight_window_config;
    next_refclk   = ref_clock_config;
    next_echo     = echo_config;
    next_irq_mask = irq_mask;
    if (wr_lane0 && aw_idx == etfr_pkg::IDX_FLIGHT_WIN) begin
      next_flight = w_data[7:0];
    end else if (wr_lane0 && aw_idx == etfr_pkg::IDX_REF_CLOCK) begin
      next_refclk = w_data[7:0];
    end else if (wr_lane0 && aw_idx == etfr_pkg::IDX_ECHO_CFG) begin
      next_echo = w_data[7:0];
    end else if (wr_lane0 && aw_idx == etfr_pkg::IDX_IRQ_MASK) begin
      next_irq_mask = w_data[3:0];
    end
    rd_go  = arvalid_in && arready_out;
    ar_idx = {2'b00, araddr_in[7:2]};
    rd_hit = 1'b1;
    next_rdata = 32'h0000_0000;
    if (ar_idx == etfr_pkg::IDX_FAULT_FLAGS) begin
      next_rdata[2:0] = fault_flags;
    end else if (ar_idx == etfr_pkg::IDX_FLIGHT_WIN) begin
      next_rdata[7:0] = flight_window_config;
    end else if (ar_idx == etfr_pkg::IDX_REF_CLOCK) begin
      next_rdata[7:0] = ref_clock_config;
    end else if (ar_idx == etfr_pkg::IDX_ECHO_CFG) begin
      next_rdata[7:0] = echo_config;
    end else if (ar_idx == etfr_pkg::IDX_IRQ_STATUS) begin
      next_rdata[3:0] = irq_status;
    end else if (ar_idx == etfr_pkg::IDX_IRQ_MASK) begin
      next_rdata[3:0] = irq_mask;
    end else if (ar_idx == etfr_pkg::IDX_MEAS_STATUS) begin
      next_rdata[7:0] = {crossings, 2'b00, state};
    end else begin
      rd_hit = 1'b0;
    end
    next_rvalid = rvalid_out;
    next_rresp  = rresp_out;
    if (rd_go) begin
      next_rvalid = 1'b1;
      next_rresp  = rd_hit ? etfr_pkg::RESP_OKAY : etfr_pkg::RESP_SLVERR;
    end else if (rready_in) begin
      next_rvalid = 1'b0;
    end
    if (!rd_go) begin
      next_rdata = rdata_out;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      aw_held              <= 1'b0;
      w_held               <= 1'b0;
      aw_idx               <= 8'h00;
      w_data               <= 32'h0000_0000;
      w_strb               <= 4'h0;
      bvalid_out           <= 1'b0;
      bresp_out            <= etfr_pkg::RESP_OKAY;
      rvalid_out           <= 1'b0;
      rresp_out            <= etfr_pkg::RESP_OKAY;
      rdata_out            <= 32'h0000_0000;
      flight_window_config <= etfr_pkg::RST_FLIGHT_WIN;
      ref_clock_config     <= etfr_pkg::RST_REF_CLOCK;
      echo_config          <= etfr_pkg::RST_ECHO_CFG;
      irq_mask             <= etfr_pkg::RST_IRQ;
    end else begin
      aw_held              <= next_aw_held;
      w_held               <= next_w_held;
      aw_idx               <= next_aw_idx;
      w_data               <= next_w_data;
      w_strb               <= next_w_strb;
      bvalid_out           <= next_bvalid;
      bresp_out            <= next_bresp;
      rvalid_out           <= next_rvalid;
      rresp_out            <= next_rresp;
      rdata_out            <= next_rdata;
      flight_window_config <= next_flight;
      ref_clock_config     <= next_refclk;
      echo_config          <= next_echo;
      irq_mask             <= next_irq_mask;
    end
  end

  // a buffered request keeps ready low until the write completes
  assign awready_out = !aw_held;
  assign wready_out  = !w_held;
  assign arready_out = !rvalid_out;

  // ------------------------------------------------------------------
  // base period strobe and measurement sequencer
  // ------------------------------------------------------------------
  always_comb begin
    next_phase = 1'b0;
    if (ref_clock_config[etfr_pkg::BIT_HALVER]) begin
      next_phase = !base_phase;
    end
    base_tick = !ref_clock_config[etfr_pkg::BIT_HALVER] || base_phase;
    abort = wr_flags && w_data[etfr_pkg::BIT_NO_ECHO];
    next_state     = state;
    next_crossings = crossings;
    next_seen      = seen;
    tmr_load       = 1'b0;
    tmr_len        = etfr_pkg::ZERO_BASE;
    timeout_evt    = 1'b0;
    done_evt       = 1'b0;
    case (state)
      etfr_pkg::ST_READY: begin
        if (rx_rise.trigger) begin
          next_state = etfr_pkg::ST_ZERO;
          tmr_load   = 1'b1;
          tmr_len    = etfr_pkg::ZERO_BASE << ref_clock_config[1:0];
        end
      end
      etfr_pkg::ST_ZERO: begin
        if (tmr_done && flight_window_config[etfr_pkg::BIT_FORCE_SHORT]) begin
          next_state = etfr_pkg::ST_BLANK;
          tmr_load   = 1'b1;
          tmr_len    = etfr_pkg::BLANK_BASE << flight_window_config[5:3];
        end else if (tmr_done) begin
          next_state = etfr_pkg::ST_LISTEN;
          tmr_load   = 1'b1;
          tmr_len    = etfr_pkg::LISTEN_BASE << flight_window_config[1:0];
        end
      end
      etfr_pkg::ST_BLANK: begin
        if (tmr_done) begin
          next_state = etfr_pkg::ST_LISTEN;
          tmr_load   = 1'b1;
          tmr_len    = etfr_pkg::LISTEN_BASE << flight_window_config[1:0];
        end
      end
      etfr_pkg::ST_LISTEN: begin
        if (rx_rise.crossing) begin
          next_crossings = crossings + 4'h1;
        end
        if (rx_rise.crossing || rx_stable.signal) begin
          next_seen = 1'b1;
        end
        if (next_crossings >= echo_config[7:4]) begin
          next_state = etfr_pkg::ST_READY;
          done_evt   = 1'b1;
        end else if (tmr_done &&
                     !flight_window_config[etfr_pkg::BIT_NO_TIMEOUT]) begin
          next_state  = etfr_pkg::ST_READY;
          timeout_evt = 1'b1;
        end
      end
      default: next_state = etfr_pkg::ST_READY;
    endcase
    if (state != etfr_pkg::ST_LISTEN) begin
      next_crossings = 4'h0;
      next_seen      = 1'b0;
    end
    if (abort) begin
      next_state  = etfr_pkg::ST_READY;
      timeout_evt = 1'b0;
      done_evt    = 1'b0;
    end
  end

  etfr_span_timer etfr_span_timer_i (
    .clk_in   (clk_in),
    .rstn_in  (rstn_in),
    .tick_in  (base_tick),
    .load_in  (tmr_load),
    .abort_in (abort),
    .len_in   (tmr_len),
    .done_out (tmr_done)
  );

  // ------------------------------------------------------------------
  // fault flags and interrupts, a set in the clearing cycle wins
  // ------------------------------------------------------------------
  always_comb begin
    none_evt = timeout_evt && !seen && !rx_rise.crossing;
    weak_evt = timeout_evt && !none_evt;
    over_evt = (state == etfr_pkg::ST_LISTEN) && rx_stable.overrange &&
               (echo_config[2:0] == etfr_pkg::THRESH_TOP);
    next_flags = fault_flags;
    if (wr_flags && w_data[etfr_pkg::BIT_OVERRANGE]) begin
      next_flags = 3'h0;
    end else if (abort) begin
      next_flags[etfr_pkg::BIT_NO_ECHO] = 1'b0;
    end
    next_flags = next_flags | {weak_evt, none_evt, over_evt};
    irq_events = {done_evt, weak_evt, none_evt, over_evt};
    next_irq_status = irq_status;
    if (wr_lane0 && aw_idx == etfr_pkg::IDX_IRQ_STATUS) begin
      next_irq_status = irq_status & ~w_data[3:0];
    end
    next_irq_status = next_irq_status | irq_events;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state           <= etfr_pkg::ST_READY;
      base_phase      <= 1'b0;
      crossings       <= 4'h0;
      seen            <= 1'b0;
      fault_flags     <= etfr_pkg::RST_FAULT_FLAGS[2:0];
      irq_status      <= etfr_pkg::RST_IRQ;
      fault_pin_n_out <= 1'b1;
      busy_out        <= 1'b0;
      irq_out         <= 1'b0;
    end else begin
      state           <= next_state;
      base_phase      <= next_phase;
      crossings       <= next_crossings;
      seen            <= next_seen;
      fault_flags     <= next_flags;
      irq_status      <= next_irq_status;
      fault_pin_n_out <= ~|next_flags;
      busy_out        <= next_state != etfr_pkg::ST_READY;
      irq_out         <= |(next_irq_status & next_irq_mask);
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  fault_pin_a: assert property (fault_pin_n_out == !(|fault_flags))
    else $error("fault pin disagrees with flags");
  clear_all_a: assert property (wr_flags && w_data[0] &&
    !timeout_evt && !over_evt |=> fault_flags == 3'h0 && fault_pin_n_out)
    else $error("over-range write did not clear flags");
  abort_ready_a: assert property (abort |=>
    state == etfr_pkg::ST_READY ##1
    (state == etfr_pkg::ST_READY || $past(rx_rise.trigger)))
    else $error("no-echo write did not abort");
  no_echo_a: assert property (timeout_evt && !seen &&
    !rx_rise.crossing |=> fault_flags[1] &&
    (!fault_flags[2] || $past(fault_flags[2])))
    else $error("no-echo flag missing");
  weak_set_a: assert property (timeout_evt && seen |=> fault_flags[2])
    else $error("weak flag missing");
  range_gate_a: assert property ($rose(fault_flags[0]) |->
    $past(echo_config[2:0]) == 3'h7)
    else $error("over-range flag without top threshold");
  short_skip_a: assert property (state == etfr_pkg::ST_ZERO &&
    tmr_done && !flight_window_config[6] && !abort
    |=> state == etfr_pkg::ST_LISTEN)
    else $error("blanking entered without force bit");
  no_timeout_a: assert property (flight_window_config[2] &&
    state == etfr_pkg::ST_LISTEN && !abort && !done_evt
    |=> state == etfr_pkg::ST_LISTEN)
    else $error("listen ended while timeout disabled");
  // a write that drops the halver may legally give back-to-back ticks
  tick_rate_a: assert property (ref_clock_config[2] && base_tick &&
    next_refclk[2] |=> !base_tick)
    else $error("halved base period too fast");
  irq_level_a: assert property (irq_out == |(irq_status & irq_mask))
    else $error("interrupt level wrong");

  full_flight_c: cover property (state == etfr_pkg::ST_BLANK
    ##[1:300] state == etfr_pkg::ST_LISTEN);
  weak_echo_c: cover property (weak_evt);
  abort_c: cover property (abort && state == etfr_pkg::ST_LISTEN);
  done_c: cover property (done_evt);

endmodule

// File: hw/etfr_pkg.sv
// Purpose: constants and carrier types for the echo timeout fault registers
// Assumes: 10 MHz clock, AXI4-Lite with 32-bit data, 8-bit address
// Notes:   byte address of a register is four times its index
package etfr_pkg;

  // ------------------------------------------------------------------
  // clock and sizes
  // ------------------------------------------------------------------
  localparam int unsigned CLK_HZ     = 10_000_000;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned LEN_W      = 11;

  // ------------------------------------------------------------------
  // register indices, byte address is index times four
  // ------------------------------------------------------------------
  localparam logic [7:0] IDX_FAULT_FLAGS  = 8'h07;
  localparam logic [7:0] IDX_FLIGHT_WIN   = 8'h08;
  localparam logic [7:0] IDX_REF_CLOCK    = 8'h09;
  localparam logic [7:0] IDX_ECHO_CFG     = 8'h0A;
  localparam logic [7:0] IDX_IRQ_STATUS   = 8'h0B;
  localparam logic [7:0] IDX_IRQ_MASK     = 8'h0C;
  localparam logic [7:0] IDX_MEAS_STATUS  = 8'h0D;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] RST_FLIGHT_WIN   = 8'h19;
  localparam logic [7:0] RST_REF_CLOCK    = 8'h00;
  localparam logic [7:0] RST_ECHO_CFG     = 8'h17;
  localparam logic [7:0] RST_FAULT_FLAGS  = 8'h00;
  localparam logic [3:0] RST_IRQ          = 4'h0;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int unsigned BIT_OVERRANGE   = 0;
  localparam int unsigned BIT_NO_ECHO     = 1;
  localparam int unsigned BIT_WEAK        = 2;
  localparam int unsigned BIT_DONE        = 3;
  localparam int unsigned BIT_FORCE_SHORT = 6;
  localparam int unsigned BLANK_LSB       = 3;
  localparam int unsigned BIT_NO_TIMEOUT  = 2;
  localparam int unsigned LISTEN_LSB      = 0;
  localparam int unsigned BIT_HALVER      = 2;
  localparam int unsigned ZERO_LSB        = 0;
  localparam int unsigned THRESH_LSB      = 0;
  localparam int unsigned EXPECT_LSB      = 4;

  // ------------------------------------------------------------------
  // durations in base periods, shifted left by the field code, and the top qualify threshold
  // ------------------------------------------------------------------
  localparam logic [10:0] BLANK_BASE      = 11'h008;
  localparam logic [10:0] LISTEN_BASE     = 11'h080;
  localparam logic [10:0] ZERO_BASE       = 11'h040;
  localparam logic [2:0]  THRESH_TOP      = 3'h7;

  // ------------------------------------------------------------------
  // bus answers
  // ------------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_READY,
    ST_ZERO,
    ST_BLANK,
    ST_LISTEN
  } etfr_state_e;

  typedef struct packed {
    logic trigger;
    logic crossing;
    logic signal;
    logic overrange;
  } etfr_rx_s;

endpackage

// File: hw/etfr_span_timer.sv
// Purpose: counts a loaded number of base periods and pulses at the end
// Assumes: tick_in is a one-cycle base period strobe
// Notes:   abort wins over load
`timescale 1ns/1ps
module etfr_span_timer (
  // clock and reset
  input  wire logic                          clk_in,
  input  wire logic                          rstn_in,
  // control
  input  wire logic                          tick_in,
  input  wire logic                          load_in,
  input  wire logic                          abort_in,
  input  wire logic [etfr_pkg::LEN_W-1:0]    len_in,
  // result
  output logic                               done_out
);

  logic [etfr_pkg::LEN_W-1:0] count;
  logic                       run;
  logic [etfr_pkg::LEN_W-1:0] next_count;
  logic                       next_run;
  logic                       next_done;

  always_comb begin
    next_count = count;
    next_run   = run;
    next_done  = 1'b0;
    if (abort_in) begin
      next_run = 1'b0;
    end else if (load_in) begin
      next_count = len_in;
      next_run   = 1'b1;
    end else if (run && tick_in) begin
      if (count == 11'h001) begin
        next_run  = 1'b0;
        next_done = 1'b1;
      end else begin
        next_count = count - 11'h001;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count    <= 11'h000;
      run      <= 1'b0;
      done_out <= 1'b0;
    end else begin
      count    <= next_count;
      run      <= next_run;
      done_out <= next_done;
    end
  end

endmodule

// File: tb/etfr_host_model.sv
// Purpose: axi4-lite master standing in for the host controller
// Assumes: tasks are entered from one process at a time
// Notes:   no fixed latency assumed, bench timeout cuts hangs
`timescale 1ns/1ps
module etfr_host_model (
  // clock
  input  wire logic        clk_in,
  // write channels
  output logic [7:0]       awaddr_out,
  output logic             awvalid_out,
  input  wire logic        awready_in,
  output logic [31:0]      wdata_out,
  output logic             wvalid_out,
  input  wire logic        wready_in,
  input  wire logic [1:0]  bresp_in,
  input  wire logic        bvalid_in,
  output logic             bready_out,
  // read channels
  output logic [7:0]       araddr_out,
  output logic             arvalid_out,
  input  wire logic        arready_in,
  input  wire logic [31:0] rdata_in,
  input  wire logic [1:0]  rresp_in,
  input  wire logic        rvalid_in,
  output logic             rready_out
);
  initial begin
    {awvalid_out, wvalid_out, bready_out, arvalid_out, rready_out} = '0;
    {awaddr_out, araddr_out, wdata_out} = '0;
  end
  // leading edge wait keeps two calls from driving one time step
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    output logic [1:0] r);
    logic aw_wait;
    logic w_wait;
    @(posedge clk_in);
    awaddr_out  <= a;
    wdata_out   <= v;
    {awvalid_out, wvalid_out, bready_out} <= 3'h7;
    {aw_wait, w_wait} = 2'h3;
    do begin
      @(posedge clk_in);
      if (aw_wait && awready_in === 1'b1) begin
        aw_wait = 1'b0;
        awvalid_out <= 1'b0;
      end
      if (w_wait && wready_in === 1'b1) begin
        w_wait = 1'b0;
        wvalid_out <= 1'b0;
      end
    end while (aw_wait || w_wait || bvalid_in !== 1'b1);
    r = bresp_in;
    bready_out <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] r);
    @(posedge clk_in);
    araddr_out <= a;
    {arvalid_out, rready_out} <= 2'h3;
    do begin
      @(posedge clk_in);
      if (arready_in === 1'b1) begin
        arvalid_out <= 1'b0;
      end
    end while (rvalid_in !== 1'b1);
    v = rdata_in;
    r = rresp_in;
    rready_out <= 1'b0;
  endtask
endmodule

// File: tb/etfr_regs_tb.sv
// Purpose: self-checking bench for the echo timeout fault registers
// Assumes: crossing and over-range pulses land inside the listen phase
// Notes:   spans get a small slack for the pin synchroniser
`timescale 1ns/1ps
module etfr_regs_tb;
  logic               clk_in, rstn_in, awvalid, awready, wvalid, wready;
  logic               bvalid, bready, arvalid, arready, rvalid, rready;
  logic               fault_n, busy, irq;
  logic [7:0]         awaddr, araddr;
  logic [31:0]        wdata, rdata, d;
  logic [1:0]         bresp, rresp, r;
  etfr_pkg::etfr_rx_s rx;
  int                 num_errors, n_checks, cyc, n;
  logic [7:0]         t_fw [4] = '{8'h00, 8'h41, 8'h1B, 8'h7A};
  logic [7:0]         t_rc [4] = '{8'h00, 8'h01, 8'h04, 8'h03};
  int                 t_len [4] = '{192, 392, 2176, 2048};
  etfr_regs etfr_regs_i (.clk_in(clk_in), .rstn_in(rstn_in),
    .awaddr_in(awaddr), .awvalid_in(awvalid), .awready_out(awready),
    .wdata_in(wdata), .wstrb_in(4'h1), .wvalid_in(wvalid),
    .wready_out(wready), .bresp_out(bresp), .bvalid_out(bvalid),
    .bready_in(bready), .araddr_in(araddr), .arvalid_in(arvalid),
    .arready_out(arready), .rdata_out(rdata), .rresp_out(rresp),
    .rvalid_out(rvalid), .rready_in(rready), .rx_in(rx),
    .fault_pin_n_out(fault_n), .busy_out(busy), .irq_out(irq));
  etfr_host_model etfr_host_model_i (.clk_in(clk_in),
    .awaddr_out(awaddr), .awvalid_out(awvalid), .awready_in(awready),
    .wdata_out(wdata), .wvalid_out(wvalid), .wready_in(wready),
    .bresp_in(bresp), .bvalid_in(bvalid), .bready_out(bready),
    .araddr_out(araddr), .arvalid_out(arvalid), .arready_in(arready),
    .rdata_in(rdata), .rresp_in(rresp), .rvalid_in(rvalid),
    .rready_out(rready));
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    etfr_host_model_i.rd(a, d, r);
    chk("rdata", e, d);
    chk("rresp", etfr_pkg::RESP_OKAY, r);
  endtask
  task wrr(input logic [7:0] a, input logic [31:0] v);
    etfr_host_model_i.wr(a, v, r);
  endtask
  task meas(input logic [7:0] fw, rc, input int cx, ov);
    rdc(8'h1C, 32'h0000_0000);
    wrr(8'h20, {24'h00_0000, fw});
    wrr(8'h24, {24'h00_0000, rc});
    @(posedge clk_in);
    rx.trigger <= 1'b1;
    repeat (2) @(posedge clk_in);
    rx.trigger <= 1'b0;
    for (int k = 0; k < 20 && busy !== 1'b1; k++) @(posedge clk_in);
    n = 0;
    while (busy === 1'b1 && n < 3000) begin
      @(posedge clk_in);
      n++;
      rx.crossing  <= (n == cx || n == cx + 1);
      rx.overrange <= (ov != 0 && n > cx && n < cx + 20);
    end
  endtask
  task complete_run;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // hang guard, full run is near nine thousand cycles
  always @(posedge clk_in) begin
    cyc++;
    if (cyc > 20000) begin
      num_errors++;
      complete_run;
    end
  end
  initial begin
    {rstn_in, rx, num_errors, n_checks, cyc} = '0;
    repeat (2) @(posedge clk_in);
    rstn_in <= 1'b1;
    chk("idle pins", 3'h4, {fault_n, busy, irq});
    rdc(8'h20, 32'h0000_0019);
    rdc(8'h24, 32'h0000_0000);
    etfr_host_model_i.wr(8'h3C, 32'h0000_0001, r);
    chk("bresp", etfr_pkg::RESP_SLVERR, r);
    wrr(8'h28, 32'h0000_0017);
    for (int i = 0; i < 4; i++) begin
      meas(t_fw[i], t_rc[i], -100, 0);
      chk("span", 1, n >= t_len[i] - 2 && n <= t_len[i] + 4);
      rdc(8'h1C, 32'h0000_0002);
      chk("fault pin", 0, fault_n);
      wrr(8'h1C, 32'h0000_0001);
      rdc(8'h1C, 32'h0000_0000);
      chk("fault pin", 1, fault_n);
    end
    chk("irq masked", 0, irq);
    wrr(8'h30, 32'h0000_0002);
    chk("irq set", 1, irq);
    wrr(8'h2C, 32'h0000_000F);
    chk("irq clear", 0, irq);
    meas(8'h04, 8'h00, -100, 0);
    chk("waits", 1, n == 3000 && busy === 1'b1);
    wrr(8'h1C, 32'h0000_0002);
    repeat (2) @(posedge clk_in);
    chk("abort", 0, busy);
    wrr(8'h28, 32'h0000_0027);
    meas(8'h00, 8'h00, 100, 1);
    rdc(8'h1C, 32'h0000_0005);
    wrr(8'h1C, 32'h0000_0001);
    wrr(8'h28, 32'h0000_0026);
    meas(8'h00, 8'h00, 100, 1);
    rdc(8'h1C, 32'h0000_0004);
    // reset after the run must drop the weak flag and restore the echo config
    rstn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rstn_in <= 1'b1;
    chk("reset pin", 1, fault_n);
    rdc(8'h1C, 32'h0000_0000);
    rdc(8'h28, 32'h0000_0017);
    meas(8'h00, 8'h00, 100, 0);
    chk("done span", 1, n > 100 && n < 192);
    rdc(8'h1C, 32'h0000_0000);
    rdc(8'h2C, 32'h0000_0008);
    complete_run;
  end
endmodule
